// ===== shared/ts_clock_defs.vh
// Constants for the timestamp clock discipline block
`ifndef TS_CLOCK_DEFS_VH
`define TS_CLOCK_DEFS_VH

// ----------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_INSEL 8'h04
`define REG_OUTSEL 8'h08
`define REG_HOST_SEC 8'h0c
`define REG_HOST_FRAC 8'h10
`define REG_THRESH 8'h14
`define REG_STATUS 8'h18
`define REG_INT_STATUS 8'h1c
`define REG_INT_MASK 8'h20
`define REG_TIME_SEC 8'h24
`define REG_TIME_FRAC 8'h28
`define REG_PHASE_ERR 8'h2c
`define REG_PULSE_TOTAL 8'h30
`define REG_PULSE_BAD 8'h34
`define REG_PULSE_MISSED 8'h38
`define REG_RATE 8'h3c

// ----------------------------------------
// Control register bits (write-one actions)
// ----------------------------------------
`define CTRL_SET_BIT 0
`define CTRL_RESET_BIT 1
`define CTRL_CLEAR_STATS_BIT 2

// ----------------------------------------
// Input selector codes
// ----------------------------------------
`define IN_NONE 3'h0
`define IN_EXT 3'h1
`define IN_HOST 3'h2
`define IN_OVER 3'h3
`define IN_AUX 3'h4

// ----------------------------------------
// Output selector codes
// ----------------------------------------
`define OUT_NONE 3'h0
`define OUT_REPEAT 3'h1
`define OUT_LOOP 3'h2
`define OUT_HOST 3'h3
`define OUT_MASTER 3'h4

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define INT_PULSE 0
`define INT_BAD 1
`define INT_MISSED 2
`define INT_LOCK_CHG 3
`define INT_WIDTH 4

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 25000000
`define CLK_NS 40
`define THRESH_NS_DEFAULT 32'd596
// Fraction step per cycle: 2^32 / 25e6
`define FRAC_STEP_DEFAULT 32'd172
`define PULSE_WIDTH_NS 1000
`define PULSE_WIDTH_CYC ((`PULSE_WIDTH_NS + `CLK_NS - 1) / `CLK_NS)
// Pulse window: 1 s +/- 10 percent
`define WIN_LO_CYC (`CLK_HZ - `CLK_HZ / 10)
`define WIN_HI_CYC (`CLK_HZ + `CLK_HZ / 10)

`endif

// ===== design/pulse_edge_detect.v
// Rising edge detector for the reference pulse inputs
`timescale 1ns/1ps
module pulse_edge_detect (
  input wire ref_clk, // Clock
  input wire srst, // Synchronous reset
  input wire pulse_in, // Level input
  output reg rise_q // One-cycle rising edge pulse
);
  reg prev_q;

  always @(posedge ref_clk) begin
    if (srst) begin
      prev_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      prev_q <= pulse_in;
      rise_q <= pulse_in & ~prev_q;
    end
  end
endmodule // pulse_edge_detect

// ===== design/ts_clock_sync.v
// Timestamp clock with pulse-per-second discipline and selectors
// Summary of operation
// - Clock loads host time at init, then free-runs from crystal.
// - Connector accepts a once-per-second pulse at differential levels.
// - Defaults select external pulse input and drive no output.
// - Input choices: none, external pulse, host-derived internal; host, aux unused.
// - Output choices: none, repeat, loop, master pulse; host unused.
// - Full reset reloads host time and restores default selectors.
// - Set loads host time, selectors untouched.
// - Synchronised only within configurable threshold, default 596 ns.
// - No active input means not synchronised and free-running.
// - Linked cards: one emits master pulse, other locks by default.
// - Card may follow host clock and emit master pulse together.
// - Valid pulse at connector starts synchronising automatically when input select is external pulse.
// - Pulse on circuit A, serial time packets on circuit B.
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "ts_clock_defs.vh"
module ts_clock_sync #(
  parameter THRESH_DEFAULT = `THRESH_NS_DEFAULT, // Health threshold ns
  parameter [31:0] WIN_LO = `WIN_LO_CYC, // Least pulse spacing
  parameter [31:0] WIN_HI = `WIN_HI_CYC, // Most pulse spacing
  parameter [31:0] SEC_CYC = `CLK_HZ // Cycles in one master second
) (
  input wire ref_clk, // 25 MHz clock
  input wire srst, // Synchronous reset
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [7:0] wb_adr_i, // Wishbone byte address
  input wire [3:0] wb_sel_i, // Wishbone byte selects
  input wire [31:0] wb_dat_i, // Wishbone write data
  output reg [31:0] wb_dat_o, // Wishbone read data
  output reg wb_ack_o, // Wishbone acknowledge
  input wire ext_pulse_a_i, // Circuit A received pulse
  input wire ser_b_i, // Circuit B serial time data
  input wire host_tick_i, // Host-derived second tick
  output reg pulse_out_a_q, // Circuit A pulse output
  output reg ser_out_b_q, // Circuit B serial output
  output reg [63:0] timestamp_q, // Seconds and binary fraction
  output reg synced_q, // Clock within threshold
  output reg irq_q // Interrupt, level
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [2:0] insel_q;
  reg [2:0] outsel_q;
  reg [31:0] host_sec_q;
  reg [31:0] host_frac_q;
  reg [31:0] thresh_q;
  reg [31:0] step_q;
  reg [31:0] phase_q;
  reg [31:0] total_q;
  reg [31:0] bad_q;
  reg [31:0] missed_q;
  reg [31:0] gap_q;
  reg [31:0] master_cnt_q;
  reg [7:0] width_q;
  reg [`INT_WIDTH-1:0] int_status_q;
  reg [`INT_WIDTH-1:0] int_mask_q;
  reg active_q;
  reg seen_q;
  reg master_q;
  wire ext_rise;
  wire host_rise;
  wire sel_rise;
  wire req;
  wire wr;
  wire set_req;
  wire full_reset;
  wire clr_stats;
  wire in_time;
  wire late;
  wire accept;
  wire [31:0] frac_next;
  wire [31:0] err_abs;
  wire [31:0] err_ns;
  wire [`INT_WIDTH-1:0] int_set;
  reg lock_ok;
  localparam integer PULSE_CYC = `PULSE_WIDTH_CYC;
  localparam [7:0] PULSE_LEN = PULSE_CYC[7:0];

  // Merge lanes by byte select
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        wmerge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Input selection active for tracking
  function sel_active;
    input [2:0] s;
    begin
      sel_active = (s == `IN_EXT) || (s == `IN_OVER);
    end
  endfunction

  // ----------------------------------------
  // Pulse edge detection
  // ----------------------------------------
  // pulse input edge
  pulse_edge_detect u_ext_edge (
    .ref_clk(ref_clk),
    .srst(srst),
    .pulse_in(ext_pulse_a_i),
    .rise_q(ext_rise)
  );

  pulse_edge_detect u_host_edge (
    .ref_clk(ref_clk),
    .srst(srst),
    .pulse_in(host_tick_i),
    .rise_q(host_rise)
  );

  assign sel_rise = (insel_q == `IN_EXT) ? ext_rise :
                    (insel_q == `IN_OVER) ? host_rise : 1'b0;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign set_req = wr && (wb_adr_i == `REG_CTRL) && wb_sel_i[0] && wb_dat_i[`CTRL_SET_BIT];
  assign full_reset = wr && (wb_adr_i == `REG_CTRL) && wb_sel_i[0] &&
                      wb_dat_i[`CTRL_RESET_BIT];
  assign clr_stats = wr && (wb_adr_i == `REG_CTRL) && wb_sel_i[0] &&
                     wb_dat_i[`CTRL_CLEAR_STATS_BIT];

  // ----------------------------------------
  // Pulse qualification
  // ----------------------------------------
  // Gap check only once a previous pulse is seen
  assign in_time = (gap_q >= WIN_LO) && (gap_q <= WIN_HI);
  assign late = seen_q && (gap_q == WIN_HI);
  assign accept = sel_rise && (!seen_q || in_time);
  assign frac_next = timestamp_q[31:0] + step_q;
  // Phase error: fraction distance to the nearest second edge
  assign err_abs = timestamp_q[31] ? (32'h0 - timestamp_q[31:0]) : timestamp_q[31:0];
  // Approx ns: frac * 1e9 / 2^32 ~ frac >> 2 (0.93 ns units)
  assign err_ns = {2'b00, err_abs[31:2]};

  always @* begin
    lock_ok = (err_ns <= thresh_q);
  end

  assign int_set = {(accept & ((lock_ok & seen_q) != synced_q)),
                    late,
                    (sel_rise & ~accept),
                    accept};

  // ----------------------------------------
  // Register writes and statistics
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      insel_q <= `IN_EXT;
      outsel_q <= `OUT_NONE;
      host_sec_q <= 32'h0;
      host_frac_q <= 32'h0;
      thresh_q <= THRESH_DEFAULT;
      int_mask_q <= {`INT_WIDTH{1'b0}};
      int_status_q <= {`INT_WIDTH{1'b0}};
      total_q <= 32'h0;
      bad_q <= 32'h0;
      missed_q <= 32'h0;
    end else begin
      if (wr) begin
        case (wb_adr_i)
          `REG_INSEL: if (wb_sel_i[0]) insel_q <= wb_dat_i[2:0];
          `REG_OUTSEL: if (wb_sel_i[0]) outsel_q <= wb_dat_i[2:0];
          `REG_HOST_SEC: host_sec_q <= wmerge(host_sec_q, wb_dat_i, wb_sel_i);
          `REG_HOST_FRAC: host_frac_q <= wmerge(host_frac_q, wb_dat_i, wb_sel_i);
          `REG_THRESH: thresh_q <= wmerge(thresh_q, wb_dat_i, wb_sel_i);
          `REG_INT_MASK: if (wb_sel_i[0]) int_mask_q <= wb_dat_i[`INT_WIDTH-1:0];
          default: ;
        endcase
      end
      if (full_reset) begin
        insel_q <= `IN_EXT;
        outsel_q <= `OUT_NONE;
      end
      // Set wins over write-one clear
      if (wr && wb_adr_i == `REG_INT_STATUS && wb_sel_i[0])
        int_status_q <= (int_status_q & ~wb_dat_i[`INT_WIDTH-1:0]) | int_set;
      else
        int_status_q <= int_status_q | int_set;
      if (clr_stats) begin
        total_q <= 32'h0;
        bad_q <= 32'h0;
        missed_q <= 32'h0;
      end else begin
        if (sel_rise)
          total_q <= total_q + 32'h1;
        if (sel_rise & ~accept)
          bad_q <= bad_q + 32'h1;
        if (late)
          missed_q <= missed_q + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Timestamp clock and discipline
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      timestamp_q <= 64'h0;
      step_q <= `FRAC_STEP_DEFAULT;
      phase_q <= 32'h0;
      gap_q <= 32'h0;
      seen_q <= 1'b0;
      active_q <= 1'b0;
      synced_q <= 1'b0;
    end else begin
      timestamp_q[31:0] <= frac_next;
      if (frac_next < timestamp_q[31:0])
        timestamp_q[63:32] <= timestamp_q[63:32] + 32'h1;
      if (gap_q != 32'hffffffff)
        gap_q <= gap_q + 32'h1;
      if (late)
        seen_q <= 1'b0;
      if (accept) begin
        gap_q <= 32'h0;
        seen_q <= 1'b1;
        active_q <= 1'b1;
        phase_q <= timestamp_q[31:0];
        if (timestamp_q[31] && err_abs > {22'h0, step_q[9:0]})
          step_q <= step_q + 32'h1;
        else if (!timestamp_q[31] && err_abs > {22'h0, step_q[9:0]})
          step_q <= step_q - 32'h1;
        // Snap to nearest second edge; whole seconds kept from the running count, plus one when the fraction is past half
        timestamp_q[31:0] <= 32'h0;
        if (timestamp_q[31])
          timestamp_q[63:32] <= timestamp_q[63:32] + 32'h1;
        else
          timestamp_q[63:32] <= timestamp_q[63:32];
        synced_q <= lock_ok && seen_q;
      end
      if (late)
        synced_q <= 1'b0;
      if (!sel_active(insel_q)) begin
        active_q <= 1'b0;
        synced_q <= 1'b0;
      end
      if (set_req || full_reset) begin
        timestamp_q <= {host_sec_q, host_frac_q};
        synced_q <= 1'b0;
        seen_q <= 1'b0;
      end
      if (full_reset)
        step_q <= `FRAC_STEP_DEFAULT;
    end
  end

  // ----------------------------------------
  // Master pulse generator and output selector
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      master_cnt_q <= 32'h0;
      master_q <= 1'b0;
      width_q <= 8'h0;
      pulse_out_a_q <= 1'b0;
      ser_out_b_q <= 1'b0;
    end else begin
      master_q <= 1'b0;
      if (accept && insel_q == `IN_OVER) begin
        master_cnt_q <= 32'h0;
        // No retrigger inside a pulse, so the width stays fixed
        master_q <= (width_q == 8'h0) && !master_q;
      end else if (master_cnt_q >= SEC_CYC - 32'h1) begin
        master_cnt_q <= 32'h0;
        master_q <= 1'b1;
      end else begin
        master_cnt_q <= master_cnt_q + 32'h1;
      end
      // First high cycle comes from master_q itself
      if (master_q)
        width_q <= PULSE_LEN - 8'h1;
      else if (width_q != 8'h0)
        width_q <= width_q - 8'h1;
      case (outsel_q)
        `OUT_REPEAT: pulse_out_a_q <= ext_pulse_a_i;
        `OUT_LOOP: pulse_out_a_q <= (insel_q == `IN_EXT) ? ext_pulse_a_i :
                                    (insel_q == `IN_OVER) ? host_tick_i : 1'b0;
        `OUT_MASTER: pulse_out_a_q <= (master_q || width_q != 8'h0);
        default: pulse_out_a_q <= 1'b0;
      endcase
      ser_out_b_q <= (outsel_q == `OUT_REPEAT) ? ser_b_i : 1'b0;
    end
  end

  // ----------------------------------------
  // Bus answer and interrupt
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      irq_q <= 1'b0;
    end else begin
      wb_ack_o <= req;
      irq_q <= |(int_status_q & int_mask_q);
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          `REG_INSEL: wb_dat_o <= {29'h0, insel_q};
          `REG_OUTSEL: wb_dat_o <= {29'h0, outsel_q};
          `REG_HOST_SEC: wb_dat_o <= host_sec_q;
          `REG_HOST_FRAC: wb_dat_o <= host_frac_q;
          `REG_THRESH: wb_dat_o <= thresh_q;
          `REG_STATUS: wb_dat_o <= {30'h0, active_q, synced_q};
          `REG_INT_STATUS: wb_dat_o <= {28'h0, int_status_q};
          `REG_INT_MASK: wb_dat_o <= {28'h0, int_mask_q};
          `REG_TIME_SEC: wb_dat_o <= timestamp_q[63:32];
          `REG_TIME_FRAC: wb_dat_o <= timestamp_q[31:0];
          `REG_PHASE_ERR: wb_dat_o <= phase_q;
          `REG_PULSE_TOTAL: wb_dat_o <= total_q;
          `REG_PULSE_BAD: wb_dat_o <= bad_q;
          `REG_PULSE_MISSED: wb_dat_o <= missed_q;
          `REG_RATE: wb_dat_o <= step_q;
          default: wb_dat_o <= 32'h0;
        endcase
      end else begin
        wb_dat_o <= 32'h0;
      end
    end
  end
endmodule // ts_clock_sync

// ===== verif/ts_clock_checker.sv
// Port assertions for the timestamp clock block
`timescale 1ns/1ps
`include "ts_clock_defs.vh"
module ts_clock_checker (
  input wire ref_clk, // Clock
  input wire srst, // Reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write
  input wire [7:0] wb_adr_i, // Address
  input wire [31:0] wb_dat_i, // Write data
  input wire [31:0] wb_dat_o, // Read data
  input wire wb_ack_o, // Ack
  input wire ext_pulse_a_i, // Pulse in
  input wire pulse_out_a_q, // Pulse out
  input wire [63:0] timestamp_q, // Time
  input wire synced_q, // Locked
  input wire irq_q // Interrupt
);
  // ------
  // Selector shadows
  // ------
  reg [2:0] insel_q;
  reg [2:0] outsel_q;
  reg [7:0] stay_q;
  reg [7:0] hi_q;
  wire wr = wb_ack_o && wb_cyc_i && wb_we_i;
  wire def_wr = wr && wb_adr_i == `REG_CTRL && wb_dat_i[`CTRL_RESET_BIT];
  wire in_wr = wr && wb_adr_i == `REG_INSEL;
  wire out_wr = wr && wb_adr_i == `REG_OUTSEL;
  always @(posedge ref_clk) begin
    insel_q <= (srst || def_wr) ? `IN_EXT : in_wr ? wb_dat_i[2:0] : insel_q;
    outsel_q <= (srst || def_wr) ? `OUT_NONE : out_wr ? wb_dat_i[2:0] : outsel_q;
    // Settle count hides the selector lag of a few cycles
    stay_q <= (srst || def_wr || in_wr || out_wr) ? 8'h00 : stay_q + {7'h0, stay_q != 8'hff};
    hi_q <= pulse_out_a_q ? hi_q + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  chk_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  chk_dat_idle:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  chk_reset_quiet:
    assert property ($past(srst) |-> !synced_q && !pulse_out_a_q && !irq_q)
    else $error("output active after reset");
  chk_time_runs:
    assert property (!$past(srst) |-> timestamp_q != $past(timestamp_q))
    else $error("time stood still");
  chk_out_none:
    assert property (outsel_q == `OUT_NONE && stay_q > 8'h04 |-> !pulse_out_a_q)
    else $error("pulse with no source");
  chk_master_width:
    assert property ($fell(pulse_out_a_q) && outsel_q == `OUT_MASTER && stay_q > 8'h40
      |-> hi_q == `PULSE_WIDTH_CYC) else $error("master width");
  chk_repeat_follow:
    assert property (outsel_q == `OUT_REPEAT && stay_q > 8'h04 && $rose(ext_pulse_a_i)
      |-> ##[1:4] pulse_out_a_q) else $error("pulse not repeated");
  chk_none_unsync:
    assert property (insel_q == `IN_NONE && stay_q > 8'h10 |-> !synced_q)
    else $error("synced with no input");
  cov_locked: cover property ($rose(synced_q));
  cov_master: cover property (outsel_q == `OUT_MASTER && $rose(pulse_out_a_q));
  cov_irq: cover property ($rose(irq_q));
endmodule // ts_clock_checker

bind ts_clock_sync ts_clock_checker u_chk (.ref_clk(ref_clk), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ext_pulse_a_i(ext_pulse_a_i), .pulse_out_a_q(pulse_out_a_q),
  .timestamp_q(timestamp_q), .synced_q(synced_q), .irq_q(irq_q));

// ===== verif/ref_pulse_model.sv
// Reference receiver: pulse on circuit A, serial data on circuit B
`timescale 1ns/1ps
module ref_pulse_model (
  input wire ref_clk, // Clock
  input wire run, // Emit pulses
  input wire [31:0] period, // Cycles between pulses
  output reg pulse_a = 1'b0, // Circuit A pulse
  output reg ser_b = 1'b0 // Circuit B data
);
  reg [31:0] cnt_q = 32'h0;
  // pulse on A, data on B
  always @(posedge ref_clk) begin
    cnt_q <= (!run || cnt_q >= period - 32'h1) ? 32'h0 : cnt_q + 32'h1;
    pulse_a <= run && cnt_q < 32'h19;
    // Data toggles so a stale copy never passes
    ser_b <= ~ser_b;
  end
endmodule // ref_pulse_model

// ===== verif/ts_clock_sync_tb_top.sv
// Self-checking bench for the timestamp clock block
`timescale 1ns/1ps
`include "ts_clock_defs.vh"
module ts_clock_sync_tb_top;
  localparam [31:0] SEC = 32'h3e8;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [31:0] wb_dat_i = 32'h0;
  reg host_tick_i = 1'b0;
  reg tick_run = 1'b0;
  reg loop_q = 1'b0;
  reg run = 1'b0;
  reg [31:0] period = SEC;
  reg [31:0] tick_cnt = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, model_a, ser_b_i, pulse_out_a_q, ser_out_b_q, synced_q, irq_q;
  wire [63:0] timestamp_q;
  integer num_errors = 0;
  integer comparisons = 0;
  integer cycles = 0;
  ts_clock_sync #(.WIN_LO(32'h384), .WIN_HI(32'h44c), .SEC_CYC(SEC)) DUT (
    .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ser_b_i(ser_b_i), .host_tick_i(host_tick_i),
    .ext_pulse_a_i(loop_q ? pulse_out_a_q : model_a), .pulse_out_a_q(pulse_out_a_q),
    .ser_out_b_q(ser_out_b_q), .timestamp_q(timestamp_q), .synced_q(synced_q), .irq_q(irq_q));
  ref_pulse_model u_ref (.ref_clk(ref_clk), .run(run), .period(period), .pulse_a(model_a),
    .ser_b(ser_b_i));
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    tick_cnt <= (tick_run && tick_cnt < SEC - 1) ? tick_cnt + 1 : 32'h0;
    host_tick_i <= tick_run && tick_cnt < 32'h19;
    cycles = cycles + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    begin
      $display("mismatches %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task check(input [63:0] seen, input [63:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // ------
  // Bus cycles and waits
  // ------
  task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge ref_clk);
      // Only ack or the bench cycle ceiling ends this wait
      while (wb_ack_o !== 1'b1)
        @(posedge ref_clk);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    reg [31:0] q;
    begin
      wb(1'b0, a, 32'h0, q);
      check(q, e);
    end
  endtask
  task wait_sync;
    integer n;
    for (n = 0; n < 5000 && synced_q !== 1'b1; n = n + 1)
      @(posedge ref_clk);
  endtask
  task watch(output sp, output ss);
    integer n;
    reg last;
    begin
      repeat (4) @(posedge ref_clk);
      sp = 1'b0;
      ss = 1'b0;
      last = ser_out_b_q;
      for (n = 0; n < 1200; n = n + 1) begin
        @(posedge ref_clk);
        sp = sp | (pulse_out_a_q === 1'b1);
        ss = ss | (ser_out_b_q !== last);
        last = ser_out_b_q;
      end
    end
  endtask
  // ------
  // Scenarios
  // ------
  task t_defaults;
    integer i;
    begin
      rd_chk(`REG_INSEL, 32'h1);
      rd_chk(`REG_OUTSEL, 32'h0);
      rd_chk(`REG_THRESH, 32'h254);
      rd_chk(`REG_INT_MASK, 32'h0);
      wr(8'h40, 32'hffff_ffff);
      rd_chk(8'h40, 32'h0);
      for (i = 0; i < 5; i = i + 1) begin
        wr(`REG_INSEL, i);
        rd_chk(`REG_INSEL, i);
        wr(`REG_OUTSEL, i);
        rd_chk(`REG_OUTSEL, i);
      end
    end
  endtask
  task t_set_full;
    begin
      wr(`REG_INSEL, 32'h0);
      wr(`REG_HOST_SEC, 32'h1234_5678);
      wr(`REG_HOST_FRAC, 32'h0);
      wr(`REG_CTRL, 32'h1);
      rd_chk(`REG_TIME_SEC, 32'h1234_5678);
      rd_chk(`REG_INSEL, 32'h0);
      rd_chk(`REG_OUTSEL, 32'h4);
      wr(`REG_HOST_SEC, 32'h0000_0abc);
      wr(`REG_CTRL, 32'h2);
      rd_chk(`REG_INSEL, 32'h1);
      rd_chk(`REG_OUTSEL, 32'h0);
      check(timestamp_q[63:32], 32'h0000_0abc);
    end
  endtask
  task t_no_input;
    reg [63:0] ts;
    begin
      wr(`REG_INSEL, 32'h0);
      wr(`REG_THRESH, 32'h0010_0000);
      wr(`REG_CTRL, 32'h4);
      run <= 1'b1;
      repeat (2500) @(posedge ref_clk);
      check(synced_q, 1'b0);
      rd_chk(`REG_PULSE_TOTAL, 32'h0);
      rd_chk(`REG_STATUS, 32'h0);
      ts = timestamp_q;
      repeat (10) @(posedge ref_clk);
      check(timestamp_q - ts, 64'h6b8);
    end
  endtask
  task t_lock_irq;
    reg [31:0] q;
    begin
      wr(`REG_INT_STATUS, 32'hf);
      wr(`REG_INSEL, 32'h1);
      wait_sync;
      check(synced_q, 1'b1);
      rd_chk(`REG_STATUS, 32'h3);
      wb(1'b0, `REG_PULSE_TOTAL, 32'h0, q);
      check(q > 32'h1 && q < 32'h5, 1'b1);
      rd_chk(`REG_PULSE_BAD, 32'h0);
      wr(`REG_THRESH, 32'h254);
      repeat (2200) @(posedge ref_clk);
      check(synced_q, 1'b0);
      wr(`REG_THRESH, 32'h0010_0000);
      wr(`REG_INT_MASK, 32'h4);
      run <= 1'b0;
      repeat (1500) @(posedge ref_clk);
      check(irq_q, 1'b1);
      wb(1'b0, `REG_PULSE_MISSED, 32'h0, q);
      check(q != 32'h0, 1'b1);
      wr(`REG_INT_STATUS, 32'hf);
      check(irq_q, 1'b0);
      wr(`REG_INT_MASK, 32'h0);
      period <= 32'h1f4;
      run <= 1'b1;
      repeat (2200) @(posedge ref_clk);
      check(irq_q, 1'b0);
      wb(1'b0, `REG_INT_STATUS, 32'h0, q);
      check(q[1], 1'b1);
      wr(`REG_INT_MASK, 32'h2);
      check(irq_q, 1'b1);
      period <= SEC;
      wr(`REG_INT_MASK, 32'h0);
    end
  endtask
  task t_outputs;
    integer k;
    reg sp, ss;
    for (k = 0; k < 4; k = k + 1) begin
      wr(`REG_OUTSEL, (k == 3) ? 32'h4 : k);
      watch(sp, ss);
      check(sp, k != 0);
      check(ss, k == 1);
    end
  endtask
  task t_host_linked;
    reg sp, ss;
    begin
      run <= 1'b0;
      tick_run <= 1'b1;
      wr(`REG_INSEL, 32'h0);
      repeat (20) @(posedge ref_clk);
      check(synced_q, 1'b0);
      wr(`REG_INSEL, 32'h3);
      wait_sync;
      check(synced_q, 1'b1);
      watch(sp, ss);
      check(sp, 1'b1);
      tick_run <= 1'b0;
      wr(`REG_INSEL, 32'h0);
      loop_q <= 1'b1;
      repeat (20) @(posedge ref_clk);
      wr(`REG_INSEL, 32'h1);
      wait_sync;
      check(synced_q, 1'b1);
    end
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_defaults;
    t_set_full;
    t_no_input;
    t_lock_irq;
    t_outputs;
    t_host_linked;
    tally_and_finish;
  end
endmodule // ts_clock_sync_tb_top
